//--- lqs_door_model.sv
// door machine model: closes at a set rate, reports width, can re-open
`timescale 1ns/1ps
`default_nettype none
module lqs_door_model (
  // control from the bench
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [1:0] bump,
  input wire logic [15:0] rate,
  // to the sequencer
  output lqs_pkg::lqs_door_t door
);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      door <= '{1'b0, 1'b0, 1'b0, 1'b0, 16'h00C8, 1'b0};
    else
    begin
      door.start_req <= go;
      door.reopen <= bump[0];
      door.curtain <= bump[1];
      if (!go || |bump)
        door.width <= 16'h00C8;
      else
        door.width <= (door.width > rate) ? door.width - rate : 16'h0000;
      door.closing <= go && door.width != 16'h0000;
      door.closed_locked <= go && door.width == 16'h0000;
    end
endmodule
`default_nettype wire

//--- lqs_pkg.sv
// package for the lift quick-start sequencer: register map, fields, timing
package lqs_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DELAY_OFS = 8'h04;
  localparam logic [7:0] TIMEOUT_OFS = 8'h08;
  localparam logic [7:0] WIDTH_OFS = 8'h0C;
  localparam logic [7:0] MAXINT_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;

  // control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_WIDTH_EN_BIT = 1;
  localparam int CTRL_HYDRAULIC_BIT = 2;

  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int TIMEOUT_MS = 10_000;
  localparam int DELAY_MS = 500;
  localparam int TICK_W = 16;

  // reset values
  localparam logic [2:0] CTRL_RST = 3'h1;
  localparam logic [15:0] DELAY_RST = 16'(DELAY_MS);
  localparam logic [15:0] TIMEOUT_RST = 16'(TIMEOUT_MS);
  localparam logic [15:0] WIDTH_RST = 16'h0064;
  localparam logic [3:0] MAXINT_RST = 4'h3;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_WAIT = 7'b0000010,
    ST_ACTIVE = 7'b0000100,
    ST_RESTORE = 7'b0001000,
    ST_RELEASE = 7'b0010000,
    ST_GO = 7'b0100000,
    ST_NORMAL = 7'b1000000
  } lqs_state_t;

  // door-side inputs
  typedef struct packed {
    logic closing;
    logic closed_locked;
    logic reopen;
    logic curtain;
    logic [15:0] width;
    logic start_req;
  } lqs_door_t;

  // outputs to the drive and safety circuit
  typedef struct packed {
    logic door_bridge_circuit;
    logic relay_drive_output;
    logic drive_power;
    logic brake_open;
    logic hold_zero_speed;
    logic drive_start;
    logic normal_start;
  } lqs_drive_t;

endpackage

//--- lqs_props_properties.sv
// port checker for the quick-start sequencer
`timescale 1ns/1ps
`default_nettype none
module lqs_props (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // drive side
  input wire lqs_pkg::lqs_drive_t drive
);
  wire logic br = drive.door_bridge_circuit;
  wire logic rl = drive.relay_drive_output;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ack_in_access_a: assert property (
    psel && !penable |=> pready) else $error("no ready");
  ack_pulse_a: assert property (
    pready |=> !pready) else $error("ready held");
  active_power_a: assert property (
    br && !rl |-> drive.drive_power) else $error("bridge without power");
  relay_first_a: assert property (
    $fell(br) && !drive.normal_start |-> rl && $past(rl)) else $error("relay order");
  start_after_a: assert property (
    $rose(drive.drive_start) |-> !br && !$past(br) && rl) else $error("early start");
  zero_hold_a: assert property (
    $rose(drive.hold_zero_speed) |-> drive.brake_open && br) else $error("hold off");
  timeout_drop_a: assert property (
    $rose(drive.normal_start) && $past(br) |-> !br && !drive.drive_power) else $error("no drop");
  go_held_a: assert property (
    drive.drive_start |-> !br && rl) else $error("start with bridge");
endmodule
bind lqs_sequencer lqs_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .drive(drive));
`default_nettype wire

//--- lqs_sequencer.sv
// lift quick-start sequencer with apb register file
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R1] bridge door chain early while doors are still closing, like re-levelling
// [R2] traction lift: brake open, drive holds cabin at zero speed until allowed
// [R3] hydraulic lift: drive powered early to build oil pressure
// [R4] relay held off during quick-start, isolating the door-lock input
// [R5] closed and locked: relay back on first, bridge released afterwards
// [R6] drive start only after relay restored and bridge released
// [R7] too many re-open or curtain interruptions force a normal start
// [R8] continuous quick-start limited by a timeout, default ten seconds
// [R9] quick-start can be switched off; then no bridging, relay stays on
// [R10] configurable delay from start of door closing before engaging
// [R11] optionally engage only once door width is below configured width
// [R12] relay driven by its own dedicated output
// [R13] on timeout: release bridge, drop drive power, do a normal start
module lqs_sequencer #(
  parameter int MS_CYC = lqs_pkg::MS_CYCLES
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // door machine and start request
  input wire lqs_pkg::lqs_door_t door,
  // drive and safety circuit
  output lqs_pkg::lqs_drive_t drive
);

  logic [2:0] ctrl_r;
  logic [15:0] delay_r;
  logic [15:0] timeout_r;
  logic [15:0] width_r;
  logic [3:0] maxint_r;
  logic [3:0] int_cnt_r;
  logic [31:0] tick_r;
  logic [15:0] ms_r;
  logic timeout_flag_r;
  lqs_pkg::lqs_state_t state_r;
  lqs_pkg::lqs_state_t state_nxt;
  logic interrupt;
  logic wr;
  logic rd;
  logic hit;
  logic traction;
  lqs_pkg::lqs_drive_t drive_nxt;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign interrupt = door.reopen || door.curtain;
  // brake opening and zero-speed hold only apply to a traction lift
  assign traction = !ctrl_r[lqs_pkg::CTRL_HYDRAULIC_BIT]; // R2
  assign hit = (paddr == lqs_pkg::CTRL_OFS) || (paddr == lqs_pkg::DELAY_OFS) ||
    (paddr == lqs_pkg::TIMEOUT_OFS) || (paddr == lqs_pkg::WIDTH_OFS) ||
    (paddr == lqs_pkg::MAXINT_OFS) || (paddr == lqs_pkg::STATUS_OFS);

  // configuration writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= lqs_pkg::CTRL_RST;
      delay_r <= lqs_pkg::DELAY_RST;
      timeout_r <= lqs_pkg::TIMEOUT_RST;
      width_r <= lqs_pkg::WIDTH_RST;
      maxint_r <= lqs_pkg::MAXINT_RST;
    end
    else if (wr)
    begin
      if (paddr == lqs_pkg::CTRL_OFS)
        ctrl_r <= pwdata[2:0]; // R9
      else if (paddr == lqs_pkg::DELAY_OFS)
        delay_r <= pwdata[15:0]; // R10
      else if (paddr == lqs_pkg::TIMEOUT_OFS)
        timeout_r <= pwdata[15:0]; // R8
      else if (paddr == lqs_pkg::WIDTH_OFS)
        width_r <= pwdata[15:0]; // R11
      else if (paddr == lqs_pkg::MAXINT_OFS)
        maxint_r <= pwdata[3:0]; // R7
    end
  end

  // apb answer: no wait state, pready registered in the setup cycle, read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (rd)
      begin
        if (paddr == lqs_pkg::CTRL_OFS)
          prdata <= {29'h0, ctrl_r};
        else if (paddr == lqs_pkg::DELAY_OFS)
          prdata <= {16'h0, delay_r};
        else if (paddr == lqs_pkg::TIMEOUT_OFS)
          prdata <= {16'h0, timeout_r};
        else if (paddr == lqs_pkg::WIDTH_OFS)
          prdata <= {16'h0, width_r};
        else if (paddr == lqs_pkg::MAXINT_OFS)
          prdata <= {28'h0, maxint_r};
        else if (paddr == lqs_pkg::STATUS_OFS)
          prdata <= {19'h0, timeout_flag_r, int_cnt_r, 1'b0, state_r};
        else
          prdata <= 32'h0000_0000;
      end
    end
  end

  // millisecond timebase, restarted on every state change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_r <= 32'h0000_0000;
      ms_r <= 16'h0000;
    end
    else if (state_nxt != state_r)
    begin
      tick_r <= 32'h0000_0000;
      ms_r <= 16'h0000;
    end
    else if (tick_r >= 32'(MS_CYC - 1))
    begin
      tick_r <= 32'h0000_0000;
      if (ms_r != 16'hFFFF)
        ms_r <= ms_r + 16'h0001;
    end
    else
      tick_r <= tick_r + 32'h0000_0001;
  end

  // interruption counter per start attempt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_cnt_r <= 4'h0;
    else if (state_r == lqs_pkg::ST_IDLE && !door.start_req)
      int_cnt_r <= 4'h0;
    else if ((state_r == lqs_pkg::ST_WAIT || state_r == lqs_pkg::ST_ACTIVE) && interrupt
      && int_cnt_r != 4'hF)
      int_cnt_r <= int_cnt_r + 4'h1; // R7
  end

  // sticky timeout status, cleared by a new start request cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timeout_flag_r <= 1'b0;
    else if (state_r == lqs_pkg::ST_ACTIVE && ms_r >= timeout_r)
      timeout_flag_r <= 1'b1; // R8
    else if (state_r == lqs_pkg::ST_IDLE && !door.start_req)
      timeout_flag_r <= 1'b0;
  end

  // quick-start sequence
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      lqs_pkg::ST_IDLE:
        if (door.start_req && door.closing)
        begin
          if (ctrl_r[lqs_pkg::CTRL_EN_BIT] && int_cnt_r < maxint_r) // R9
            state_nxt = lqs_pkg::ST_WAIT;
          else
            state_nxt = lqs_pkg::ST_NORMAL; // R7
        end
        else if (door.start_req && door.closed_locked)
          state_nxt = lqs_pkg::ST_NORMAL;
      lqs_pkg::ST_WAIT:
        if (interrupt)
          state_nxt = lqs_pkg::ST_IDLE;
        else if (door.closed_locked)
          state_nxt = lqs_pkg::ST_NORMAL;
        else if (ms_r >= delay_r &&
          (!ctrl_r[lqs_pkg::CTRL_WIDTH_EN_BIT] || door.width <= width_r)) // R10 R11
          state_nxt = lqs_pkg::ST_ACTIVE;
      lqs_pkg::ST_ACTIVE:
        if (ms_r >= timeout_r)
          state_nxt = lqs_pkg::ST_NORMAL; // R13
        else if (interrupt)
          state_nxt = lqs_pkg::ST_IDLE;
        else if (door.closed_locked)
          state_nxt = lqs_pkg::ST_RESTORE; // R5
      lqs_pkg::ST_RESTORE:
        state_nxt = lqs_pkg::ST_RELEASE; // R5
      lqs_pkg::ST_RELEASE:
        state_nxt = lqs_pkg::ST_GO; // R6
      lqs_pkg::ST_GO:
        if (!door.start_req)
          state_nxt = lqs_pkg::ST_IDLE;
      lqs_pkg::ST_NORMAL:
        if (!door.start_req)
          state_nxt = lqs_pkg::ST_IDLE;
      default:
        state_nxt = lqs_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= lqs_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // output pattern per next state, registered below
  always_comb
  begin
    case (state_nxt)
      lqs_pkg::ST_ACTIVE:
      begin
        drive_nxt.door_bridge_circuit = 1'b1; // R1
        drive_nxt.relay_drive_output = 1'b0; // R4 R12
        drive_nxt.drive_power = 1'b1; // R3
        drive_nxt.brake_open = traction; // R2
        drive_nxt.hold_zero_speed = traction; // R2
        drive_nxt.drive_start = 1'b0;
        drive_nxt.normal_start = 1'b0;
      end
      lqs_pkg::ST_RESTORE:
      begin
        drive_nxt.door_bridge_circuit = 1'b1; // R5
        drive_nxt.relay_drive_output = 1'b1; // R5
        drive_nxt.drive_power = 1'b1;
        drive_nxt.brake_open = traction;
        drive_nxt.hold_zero_speed = traction;
        drive_nxt.drive_start = 1'b0;
        drive_nxt.normal_start = 1'b0;
      end
      lqs_pkg::ST_RELEASE:
      begin
        drive_nxt.door_bridge_circuit = 1'b0; // R5
        drive_nxt.relay_drive_output = 1'b1;
        drive_nxt.drive_power = 1'b1;
        drive_nxt.brake_open = traction;
        drive_nxt.hold_zero_speed = traction;
        drive_nxt.drive_start = 1'b0; // R6
        drive_nxt.normal_start = 1'b0;
      end
      lqs_pkg::ST_GO:
      begin
        drive_nxt.door_bridge_circuit = 1'b0;
        drive_nxt.relay_drive_output = 1'b1;
        drive_nxt.drive_power = 1'b1;
        drive_nxt.brake_open = traction;
        drive_nxt.hold_zero_speed = 1'b0;
        drive_nxt.drive_start = 1'b1; // R6
        drive_nxt.normal_start = 1'b0;
      end
      lqs_pkg::ST_NORMAL:
      begin
        drive_nxt.door_bridge_circuit = 1'b0; // R13
        drive_nxt.relay_drive_output = 1'b1;
        drive_nxt.drive_power = 1'b0; // R13
        drive_nxt.brake_open = 1'b0;
        drive_nxt.hold_zero_speed = 1'b0;
        drive_nxt.drive_start = 1'b0;
        drive_nxt.normal_start = 1'b1; // R7 R13
      end
      default:
      begin
        // idle and waiting: relay stays energised, nothing bridged
        drive_nxt.door_bridge_circuit = 1'b0; // R9
        drive_nxt.relay_drive_output = 1'b1; // R9
        drive_nxt.drive_power = 1'b0;
        drive_nxt.brake_open = 1'b0;
        drive_nxt.hold_zero_speed = 1'b0;
        drive_nxt.drive_start = 1'b0;
        drive_nxt.normal_start = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      drive <= '{default: 1'b0, relay_drive_output: 1'b1};
    else
      drive <= drive_nxt;
  end

endmodule
`default_nettype wire

//--- test_lift_quick_start_sequencer.sv
// self-checking bench for the quick-start sequencer
`timescale 1ns/1ps
`default_nettype none
module test_lift_quick_start_sequencer;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic go = 1'b0;
  logic [1:0] bump = 2'h0;
  logic [15:0] rate = 16'h0001;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [31:0] rv [5] = '{32'h1, 32'h1F4, 32'h2710, 32'h64, 32'h3};
  logic pready, pslverr, e;
  lqs_pkg::lqs_door_t door;
  lqs_pkg::lqs_drive_t drive;
  int mismatches = 0;
  int check_count = 0;
  int i;
  always #20 pclk = ~pclk;
  lqs_sequencer #(.MS_CYC(10)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .door(door), .drive(drive));
  lqs_door_model far (.pclk(pclk), .presetn(presetn), .go(go), .bump(bump), .rate(rate),
    .door(door));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [31:0] c, input logic [15:0] r);
    apb(1'b1, 8'h00, c);
    rate <= r;
    go <= 1'b1;
    for (i = 0; i < 400 && drive.door_bridge_circuit !== 1'b1; i++) @(negedge pclk);
  endtask
  task automatic fin(input string n);
    for (i = 0; i < 400 && drive.door_bridge_circuit !== 1'b0; i++) @(negedge pclk);
    @(posedge pclk);
    go <= 1'b0;
    bump <= 2'h0;
    repeat (4) @(posedge pclk);
    $display("test %s done", n);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #(40 * 30000);
    mismatches++;
    wrap_up;
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    chk(32'(drive), 32'h20);
    presetn <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b0, 8'(4 * k), 32'h0);
      chk(q, rv[k]);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(e), 32'h1);
    chk(q, 32'h0);
    fin("registers");
    apb(1'b1, 8'h04, 32'h2);
    apb(1'b1, 8'h08, 32'h3E8);
    run(32'h1, 16'h1);
    chk(32'(i > 10 && i < 35), 32'h1);
    chk(32'(drive[6:2]), 32'h17);
    for (i = 0; i < 400 && drive.drive_start !== 1'b1; i++) @(negedge pclk);
    chk(32'(drive[6:5]), 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(q[6:0]), 32'h20);
    fin("traction");
    run(32'h5, 16'h1);
    chk(32'(drive[6:2]), 32'h14);
    for (i = 0; i < 400 && drive.drive_start !== 1'b1; i++) @(negedge pclk);
    chk(32'(drive[3:1]), 32'h1);
    fin("hydraulic");
    apb(1'b1, 8'h0C, 32'h32);
    run(32'h3, 16'h1);
    chk(32'(door.width <= 16'h0032 && door.width > 16'h0028), 32'h1);
    fin("width");
    run(32'h0, 16'h1);
    chk(32'(drive[6:5]), 32'h1);
    chk(32'(drive.normal_start), 32'h1);
    fin("disabled");
    apb(1'b1, 8'h10, 32'h2);
    apb(1'b1, 8'h00, 32'h1);
    go <= 1'b1;
    for (int k = 1; k < 3; k++)
    begin
      repeat (6) @(posedge pclk);
      bump <= 2'(k);
      @(posedge pclk);
      bump <= 2'h0;
    end
    for (i = 0; i < 400 && drive.normal_start !== 1'b1; i++) @(negedge pclk);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(q[11:0]), 32'h240);
    fin("interrupt");
    apb(1'b1, 8'h08, 32'h3);
    run(32'h1, 16'h0);
    for (i = 0; i < 400 && drive.normal_start !== 1'b1; i++) @(negedge pclk);
    chk(32'(i > 18 && i < 36), 32'h1);
    chk(32'({drive.door_bridge_circuit, drive.drive_power}), 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'({q[12], q[6:0]}), 32'hC0);
    fin("timeout");
    wrap_up;
  end
endmodule
`default_nettype wire
